// [logic/mbs_pkg.sv]
// Shared constants, types and helpers of the serial slave port.
// Assumes a single 40 MHz clock drives every user of this package.
package mbs_pkg;

  // Clock and character timing.
  localparam int CLK_HZ = 40_000_000;
  localparam int BAUD_RATE [8] = '{1200, 2400, 4800, 9600,
                                   19200, 38400, 57600, 115200};
  // Silent interval of 3.5 characters of 11 bits, rounded up to bits.
  localparam int GAP_BITS = 39;
  localparam logic [3:0] BITS_NO_PARITY = 4'ha;
  localparam logic [3:0] BITS_PARITY = 4'hb;

  // Addressing.
  localparam logic [7:0] BCAST_ADDR = 8'h00;
  localparam logic [15:0] MIN_SLAVE_ADDR = 16'h0001;
  localparam logic [15:0] MAX_SLAVE_ADDR = 16'h00f7;

  // Function codes, exception codes and frame lengths.
  localparam logic [7:0] FC_READ = 8'h03;
  localparam logic [7:0] FC_COIL = 8'h05;
  localparam logic [7:0] FC_WR1 = 8'h06;
  localparam logic [7:0] FC_WRN = 8'h10;
  localparam logic [7:0] EX_NONE = 8'h00;
  localparam logic [7:0] EX_FUNC = 8'h01;
  localparam logic [7:0] EX_ADDR = 8'h02;
  localparam logic [7:0] EX_VAL = 8'h03;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam int BUF_BYTES = 16;
  localparam int MAX_REGS = 3;
  localparam int ECHO_LEN = 6;
  localparam logic [4:0] REQ_LEN = 5'h08;
  localparam logic [4:0] WRN_BASE = 5'h09;
  localparam logic [4:0] MIN_FRAME = 5'h04;
  localparam logic [4:0] RD_HDR_LEN = 5'h03;
  localparam logic [4:0] EXC_LEN = 5'h03;
  localparam logic [4:0] ECHO_LEN5 = 5'h06;

  // Register indices.
  localparam logic [15:0] REG_SP = 16'h0000;
  localparam logic [15:0] REG_PV = 16'h0001;
  localparam logic [15:0] REG_POWER = 16'h0002;
  localparam logic [15:0] REG_SPEED = 16'h0003;
  localparam logic [15:0] REG_PARITY = 16'h0004;
  localparam logic [15:0] REG_ADDR = 16'h0005;
  localparam logic [15:0] REG_SP_LOW = 16'h0006;
  localparam logic [15:0] REG_SP_UPPER = 16'h0007;
  localparam logic [15:0] REG_PV_HIGH = 16'h0008;
  localparam logic [15:0] REG_DEC_POS = 16'h0009;
  localparam logic [16:0] NUM_REGS = 17'h0000a;

  // Coils, value limits and reset values.
  localparam int COILS = 4;
  localparam logic [15:0] COIL_ON = 16'hff00;
  localparam logic [15:0] COIL_OFF = 16'h0000;
  localparam logic [15:0] POWER_MAX = 16'h03e8;
  localparam logic signed [15:0] TEMP_SCALE = 16'sh000a;
  localparam logic [15:0] SP_LOW_RST = 16'h0000;
  localparam logic [15:0] SP_UPPER_RST = 16'h03e8;
  localparam logic [15:0] PV_HIGH_RST = 16'h03e8;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;

  // Parity selections.
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;

  typedef struct packed {
    logic [2:0] speed;
    logic [1:0] parity;
    logic [7:0] addr;
  } mbs_cfg_t;

  typedef struct packed {
    logic [15:0] pv;
    logic [15:0] power;
    logic [15:0] remoteSp;
    logic useRemote;
    logic isTemp;
  } mbs_proc_t;

  typedef enum logic [1:0] {LN_IDLE = 2'b01, LN_BITS = 2'b10} mbs_line_t;
  typedef enum logic [3:0] {S_RX = 4'b0001, S_EXEC = 4'b0010,
                            S_TX = 4'b0100, S_DRAIN = 4'b1000} mbs_state_t;

  // Clocks per bit for a line speed selection.
  function automatic logic [15:0] bitDivisor(input logic [2:0] sel);
    bitDivisor = 16'(CLK_HZ / BAUD_RATE[sel]);
  endfunction : bitDivisor

  // One byte step of the frame check, low bit first.
  function automatic logic [15:0] crcByte(input logic [15:0] c,
                                         input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crcByte

endpackage : mbs_pkg

// [logic/mbs_uart.sv]
// Character engine: receiver, transmitter and silent-gap detector.
// Assumes speed and parity come from logic on the same clock.
`timescale 1ns/1ps
module mbs_uart (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Line settings.
  input wire logic [2:0] speed,
  input wire logic [1:0] parity,
  // Bus pin.
  input wire logic lineIn,
  output logic lineOut,
  output logic lineOe,
  // Received characters.
  output logic rxValid,
  output logic [7:0] rxData,
  output logic rxErr,
  output logic gap,
  // Characters to send.
  input wire logic txValid,
  input wire logic [7:0] txData,
  output logic txReady
);
  import mbs_pkg::*;

  typedef struct packed {
    logic [1:0] sync;
    mbs_line_t rxSt;
    logic [15:0] rxDiv;
    logic [3:0] rxBit;
    logic [10:0] rxSh;
    logic rxValid;
    logic [7:0] rxData;
    logic rxErr;
    logic [23:0] idle;
    logic gapArmed;
    logic gap;
    mbs_line_t txSt;
    logic [15:0] txDiv;
    logic [3:0] txBit;
    logic [10:0] txSh;
    logic lineOut;
    logic lineOe;
    logic txReady;
  } mbs_uart_t;

  mbs_uart_t s_r, s_nxt;
  logic [15:0] div;
  logic [3:0] nbits;
  logic [23:0] gapLim;
  logic [7:0] dat;
  logic parBit;
  logic [10:0] txFrame;

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic for both directions.
  always_comb begin
    s_nxt = s_r;
    s_nxt.sync = {s_r.sync[0], lineIn};
    s_nxt.rxValid = 1'b0;
    s_nxt.gap = 1'b0;
    div = bitDivisor(speed);
    nbits = (parity == PAR_NONE) ? BITS_NO_PARITY : BITS_PARITY;
    gapLim = 24'(div) * 24'(GAP_BITS);
    dat = 8'h00;
    parBit = 1'b0;
    // Outgoing frame, low bit first: start, data, parity or stop, stop.
    txFrame = {1'b1, (parity == PAR_NONE) || (^txData ^ (parity == PAR_ODD)),
               txData, 1'b0};
    unique case (s_r.rxSt)
      LN_IDLE: begin
        if (s_r.idle < gapLim) begin
          s_nxt.idle = s_r.idle + 24'h000001;
        end else if (s_r.gapArmed) begin
          s_nxt.gap = 1'b1;
          s_nxt.gapArmed = 1'b0;
        end
        if (!s_r.sync[1]) begin
          s_nxt.rxSt = LN_BITS;
          s_nxt.rxDiv = div >> 1;
          s_nxt.rxBit = 4'h0;
          s_nxt.idle = 24'h000000;
        end
      end
      LN_BITS: begin
        if (s_r.rxDiv == 16'h0000) begin
          s_nxt.rxDiv = div - 16'h0001;
          s_nxt.rxSh = {s_r.sync[1], s_r.rxSh[10:1]};
          s_nxt.rxBit = s_r.rxBit + 4'h1;
          if (s_r.rxBit == 4'h0 && s_r.sync[1]) begin
            s_nxt.rxSt = LN_IDLE; // A glitch, not a start bit.
          end else if (s_r.rxBit == nbits - 4'h1) begin
            // Last sample is the stop bit; data and parity sit below it.
            dat = (parity == PAR_NONE) ? s_nxt.rxSh[9:2] : s_nxt.rxSh[8:1];
            parBit = (parity == PAR_NONE) ? 1'b0 :
                     (^dat ^ s_nxt.rxSh[9] ^ (parity == PAR_ODD));
            s_nxt.rxSt = LN_IDLE;
            s_nxt.rxValid = 1'b1;
            s_nxt.rxData = dat;
            s_nxt.rxErr = !s_r.sync[1] || parBit;
            s_nxt.gapArmed = 1'b1;
            s_nxt.idle = 24'h000000;
          end
        end else begin
          s_nxt.rxDiv = s_r.rxDiv - 16'h0001;
        end
      end
    endcase
    unique case (s_r.txSt)
      LN_IDLE: begin
        s_nxt.lineOut = 1'b1;
        s_nxt.lineOe = 1'b0;
        s_nxt.txReady = 1'b1;
        if (txValid && s_r.txReady) begin
          s_nxt.txSh = txFrame;
          s_nxt.txBit = 4'h0;
          s_nxt.txDiv = div - 16'h0001;
          s_nxt.lineOut = 1'b0;
          s_nxt.lineOe = 1'b1;
          s_nxt.txReady = 1'b0;
          s_nxt.txSt = LN_BITS;
        end
      end
      LN_BITS: begin
        if (s_r.txDiv != 16'h0000) begin
          s_nxt.txDiv = s_r.txDiv - 16'h0001;
          // Ready one cycle early so the next byte follows with no gap.
          s_nxt.txReady = (s_r.txBit == nbits - 4'h1) &&
                          (s_r.txDiv == 16'h0001);
        end else if (s_r.txBit == nbits - 4'h1 && txValid) begin
          // Next byte starts right after the stop bit, driver kept on.
          s_nxt.txSh = txFrame;
          s_nxt.txBit = 4'h0;
          s_nxt.txDiv = div - 16'h0001;
          s_nxt.lineOut = 1'b0;
          s_nxt.txReady = 1'b0;
        end else if (s_r.txBit == nbits - 4'h1) begin
          // Driver drops right at the end of the last stop bit.
          s_nxt.lineOe = 1'b0;
          s_nxt.lineOut = 1'b1;
          s_nxt.txReady = 1'b1;
          s_nxt.txSt = LN_IDLE;
        end else begin
          s_nxt.txBit = s_r.txBit + 4'h1;
          s_nxt.txSh = {1'b1, s_r.txSh[10:1]};
          s_nxt.lineOut = s_r.txSh[1];
          s_nxt.txDiv = div - 16'h0001;
        end
      end
    endcase
  end

  // State register.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_r <= '0;
      s_r.sync <= 2'b11;
      s_r.rxSt <= LN_IDLE;
      s_r.txSt <= LN_IDLE;
      s_r.lineOut <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register.
  assign lineOut = s_r.lineOut;
  assign lineOe = s_r.lineOe;
  assign rxValid = s_r.rxValid;
  assign rxData = s_r.rxData;
  assign rxErr = s_r.rxErr;
  assign gap = s_r.gap;
  assign txReady = s_r.txReady;

endmodule : mbs_uart

// [logic/mbs_modbus_slave.sv]
// Serial slave port: frames requests, runs the supported function codes
// on a small holding-register map and sends replies.
// Assumes settings and process inputs come from logic on the same clock.
//
// Notes on behaviour
// - The port only answers requests; it never starts a transmission itself.
// - A request to our own address gets a reply frame.
// - Broadcast requests are executed but never answered.
// - Address zero is the broadcast address.
// - Characters carry eight data bits, one stop bit, selectable parity.
// - One master, up to 31 slaves, slave addresses up to 247.
// - Reply starts no later than 100 ms after the request ends.
// - Line driver is released within 2 ms after the last byte.
// - Supported: read registers, force coil, write one, write many.
// - Line speed, parity and own address are held locally and applied.
// - Every configurable setting is readable and writable over the map.
// - Register 0 reads the active setpoint; writes clamp the main one.
// - Register 1 is the bounded process value, read only.
// - Temperature process values are returned multiplied by ten.
// - Register 2 is output power, 0 to 1000, read only.
`timescale 1ns/1ps
module mbs_modbus_slave (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Bus pin, split into level, drive and enable.
  input wire logic busIn,
  output logic busOut,
  output logic busOe,
  // Settings loaded after reset and process values.
  input wire mbs_pkg::mbs_cfg_t startCfg,
  input wire mbs_pkg::mbs_proc_t proc,
  // Held settings and outputs toward the controller.
  output mbs_pkg::mbs_cfg_t activeCfg,
  output logic [15:0] mainSetpoint,
  output logic [15:0] setpointLowLimit,
  output logic [15:0] setpointUpperLimit,
  output logic [15:0] setpointHighLimit,
  output logic [15:0] decimalPosition,
  output logic [mbs_pkg::COILS-1:0] coils
);
  import mbs_pkg::*;

  typedef struct packed {
    mbs_state_t st;
    logic loaded;
    mbs_cfg_t cfg;
    mbs_cfg_t live;
    logic [BUF_BYTES-1:0][7:0] rxBuf;
    logic [4:0] rxCnt;
    logic [15:0] rxCrc;
    logic rxBad;
    logic [BUF_BYTES-1:0][7:0] txBuf;
    logic [4:0] txLen;
    logic [4:0] txIdx;
    logic [15:0] txCrc;
    logic [15:0] sp;
    logic [15:0] spLow;
    logic [15:0] spUpper;
    logic [15:0] pvHigh;
    logic [15:0] decPos;
    logic [COILS-1:0] coils;
  } mbs_main_t;

  mbs_main_t s_r, s_nxt;
  logic rxValid, rxErr, gap, txReady, txValid;
  logic [7:0] rxData, txByte;
  logic [15:0] pvOut, powerOut;
  logic [7:0] fc, exc;
  logic [15:0] a0, v0, w;
  logic frameOk;

  ////////////////////////////////////////////////////////////////////////
  // Character engine on the configured line settings.
  mbs_uart uart (
    .clk(clk),
    .reset_n(reset_n),
    .speed(s_r.live.speed),
    .parity(s_r.live.parity),
    .lineIn(busIn),
    .lineOut(busOut),
    .lineOe(busOe),
    .rxValid(rxValid),
    .rxData(rxData),
    .rxErr(rxErr),
    .gap(gap),
    .txValid(txValid),
    .txData(txByte),
    .txReady(txReady)
  );

  ////////////////////////////////////////////////////////////////////////
  // Process value scaled and bounded, output power bounded.
  always_comb begin
    pvOut = proc.isTemp ? 16'($signed(proc.pv) * TEMP_SCALE) : proc.pv;
    if ($signed(pvOut) < $signed(s_r.spLow)) begin
      pvOut = s_r.spLow;
    end else if ($signed(pvOut) > $signed(s_r.pvHigh)) begin
      pvOut = s_r.pvHigh;
    end
    powerOut = (proc.power > POWER_MAX) ? POWER_MAX : proc.power;
  end

  // Register read view.
  function automatic logic [15:0] regRead(input logic [15:0] idx);
    unique case (idx)
      REG_SP: regRead = proc.useRemote ? proc.remoteSp : s_r.sp;
      REG_PV: regRead = pvOut;
      REG_POWER: regRead = powerOut;
      REG_SPEED: regRead = 16'(s_r.cfg.speed);
      REG_PARITY: regRead = 16'(s_r.cfg.parity);
      REG_ADDR: regRead = 16'(s_r.cfg.addr);
      REG_SP_LOW: regRead = s_r.spLow;
      REG_SP_UPPER: regRead = s_r.spUpper;
      REG_PV_HIGH: regRead = s_r.pvHigh;
      REG_DEC_POS: regRead = s_r.decPos;
      default: regRead = 16'h0000;
    endcase
  endfunction : regRead

  // Exception code for a register write, none when it is allowed.
  function automatic logic [7:0] wrCheck(input logic [15:0] idx,
                                         input logic [15:0] val);
    unique case (idx)
      REG_SP, REG_SP_LOW, REG_SP_UPPER, REG_PV_HIGH, REG_DEC_POS:
        wrCheck = EX_NONE;
      REG_SPEED: wrCheck = (val > 16'(3'h7)) ? EX_VAL : EX_NONE;
      REG_PARITY: wrCheck = (val > 16'(PAR_ODD)) ? EX_VAL : EX_NONE;
      REG_ADDR: wrCheck = (val < MIN_SLAVE_ADDR || val > MAX_SLAVE_ADDR) ?
                          EX_VAL : EX_NONE;
      default: wrCheck = EX_ADDR;
    endcase
  endfunction : wrCheck

  // Applies one checked register write.
  function automatic mbs_main_t regWrite(input mbs_main_t t,
                                         input logic [15:0] idx,
                                         input logic [15:0] val);
    regWrite = t;
    unique case (idx)
      REG_SP: begin
        if ($signed(val) < $signed(t.spLow)) begin
          regWrite.sp = t.spLow;
        end else if ($signed(val) > $signed(t.spUpper)) begin
          regWrite.sp = t.spUpper;
        end else begin
          regWrite.sp = val;
        end
      end
      REG_SPEED: regWrite.cfg.speed = val[2:0];
      REG_PARITY: regWrite.cfg.parity = val[1:0];
      REG_ADDR: regWrite.cfg.addr = val[7:0];
      REG_SP_LOW: regWrite.spLow = val;
      REG_SP_UPPER: regWrite.spUpper = val;
      REG_PV_HIGH: regWrite.pvHigh = val;
      REG_DEC_POS: regWrite.decPos = val;
      default: regWrite = t;
    endcase
  endfunction : regWrite

  ////////////////////////////////////////////////////////////////////////
  // Byte offered to the transmitter: payload, then check sum low, high.
  assign txValid = (s_r.st == S_TX);
  assign txByte = (s_r.txIdx < s_r.txLen) ? s_r.txBuf[s_r.txIdx[3:0]] :
                  (s_r.txIdx == s_r.txLen) ? s_r.txCrc[7:0] :
                  s_r.txCrc[15:8];

  // A whole frame is kept when it has four to sixteen bytes, no character error, a matching check sum and our own or the broadcast address.
  assign frameOk = s_r.rxCnt >= MIN_FRAME && s_r.rxCrc == 16'h0000 &&
                   !s_r.rxBad && (s_r.rxBuf[0] == s_r.live.addr ||
                   s_r.rxBuf[0] == BCAST_ADDR);

  ////////////////////////////////////////////////////////////////////////
  // Frame sequencer.
  always_comb begin
    s_nxt = s_r;
    fc = s_r.rxBuf[1];
    a0 = {s_r.rxBuf[2], s_r.rxBuf[3]};
    v0 = {s_r.rxBuf[4], s_r.rxBuf[5]};
    exc = EX_NONE;
    w = 16'h0000;
    if (!s_r.loaded) begin
      s_nxt.cfg = startCfg;
      s_nxt.live = startCfg;
      s_nxt.loaded = 1'b1;
    end
    unique case (s_r.st)
      S_RX: begin
        if (rxValid) begin
          if (s_r.rxCnt < 5'(BUF_BYTES)) begin
            s_nxt.rxBuf[s_r.rxCnt[3:0]] = rxData;
            s_nxt.rxCnt = s_r.rxCnt + 5'h01;
          end else begin
            s_nxt.rxBad = 1'b1;
          end
          s_nxt.rxCrc = crcByte(s_r.rxCrc, rxData);
          s_nxt.rxBad = s_nxt.rxBad || rxErr;
        end else if (gap) begin
          if (frameOk) begin
            s_nxt.st = S_EXEC;
          end else begin
            s_nxt.rxCnt = 5'h00;
            s_nxt.rxCrc = CRC_INIT;
            s_nxt.rxBad = 1'b0;
          end
        end
      end
      S_EXEC: begin
        for (int i = 0; i < ECHO_LEN; i++) begin
          s_nxt.txBuf[i] = s_r.rxBuf[i];
        end
        s_nxt.txLen = ECHO_LEN5;
        case (fc)
          FC_READ: begin
            if (s_r.rxCnt != REQ_LEN || v0 == 16'h0000 ||
                v0 > 16'(MAX_REGS)) begin
              exc = EX_VAL;
            end else if ({1'b0, a0} + {1'b0, v0} > NUM_REGS) begin
              exc = EX_ADDR;
            end else begin
              s_nxt.txBuf[2] = {v0[6:0], 1'b0};
              s_nxt.txLen = RD_HDR_LEN + {v0[3:0], 1'b0};
              for (int i = 0; i < MAX_REGS; i++) begin
                w = regRead(a0 + 16'(i));
                s_nxt.txBuf[3 + 2 * i] = w[15:8];
                s_nxt.txBuf[4 + 2 * i] = w[7:0];
              end
            end
          end
          FC_COIL: begin
            if (s_r.rxCnt != REQ_LEN || (v0 != COIL_ON && v0 != COIL_OFF)) begin
              exc = EX_VAL;
            end else if (a0 >= 16'(COILS)) begin
              exc = EX_ADDR;
            end else begin
              s_nxt.coils[a0[1:0]] = (v0 == COIL_ON);
            end
          end
          FC_WR1: begin
            exc = (s_r.rxCnt != REQ_LEN) ? EX_VAL : wrCheck(a0, v0);
            if (exc == EX_NONE) begin
              s_nxt = regWrite(s_nxt, a0, v0);
            end
          end
          FC_WRN: begin
            if (v0 == 16'h0000 || v0 > 16'(MAX_REGS) ||
                s_r.rxBuf[6] != {v0[6:0], 1'b0} ||
                s_r.rxCnt != WRN_BASE + {v0[3:0], 1'b0}) begin
              exc = EX_VAL;
            end
            // Every target is checked before any of them is written.
            for (int i = 0; i < MAX_REGS; i++) begin
              if (exc == EX_NONE && 16'(i) < v0) begin
                exc = wrCheck(a0 + 16'(i),
                              {s_r.rxBuf[7 + 2 * i], s_r.rxBuf[8 + 2 * i]});
              end
            end
            for (int i = 0; i < MAX_REGS; i++) begin
              if (exc == EX_NONE && 16'(i) < v0) begin
                s_nxt = regWrite(s_nxt, a0 + 16'(i),
                            {s_r.rxBuf[7 + 2 * i], s_r.rxBuf[8 + 2 * i]});
              end
            end
          end
          default: exc = EX_FUNC;
        endcase
        if (exc != EX_NONE) begin
          s_nxt.txBuf[1] = fc | EXC_FLAG;
          s_nxt.txBuf[2] = exc;
          s_nxt.txLen = EXC_LEN;
        end
        s_nxt.txIdx = 5'h00;
        s_nxt.txCrc = CRC_INIT;
        // Reply starts at once, far inside the allowed delay.
        s_nxt.st = (s_r.rxBuf[0] == BCAST_ADDR) ? S_DRAIN : S_TX;
      end
      S_TX: begin
        if (txReady) begin
          s_nxt.txIdx = s_r.txIdx + 5'h01;
          if (s_r.txIdx < s_r.txLen) begin
            s_nxt.txCrc = crcByte(s_r.txCrc, txByte);
          end
          if (s_r.txIdx == s_r.txLen + 5'h01) begin
            s_nxt.st = S_DRAIN;
          end
        end
      end
      S_DRAIN: begin
        // New line settings take effect only once the reply is out.
        if (txReady) begin
          s_nxt.live = s_r.cfg;
          s_nxt.st = S_RX;
          s_nxt.rxCnt = 5'h00;
          s_nxt.rxCrc = CRC_INIT;
          s_nxt.rxBad = 1'b0;
        end
      end
    endcase
  end

  // State register.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_r <= '0;
      s_r.st <= S_RX;
      s_r.rxCrc <= CRC_INIT;
      s_r.txCrc <= CRC_INIT;
      s_r.spLow <= SP_LOW_RST;
      s_r.spUpper <= SP_UPPER_RST;
      s_r.pvHigh <= PV_HIGH_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register.
  assign activeCfg = s_r.live;
  assign mainSetpoint = s_r.sp;
  assign setpointLowLimit = s_r.spLow;
  assign setpointUpperLimit = s_r.spUpper;
  assign setpointHighLimit = s_r.pvHigh;
  assign decimalPosition = s_r.decPos;
  assign coils = s_r.coils;

endmodule : mbs_modbus_slave

// [tb/mbs_modbus_slave_asserts.sv]
// Checker of the slave port's line timing and held settings.
// Assumes one clock and a bus that idles high when nobody drives it.
`timescale 1ns/1ps
module mbs_modbus_slave_asserts
  import mbs_pkg::*;
(
  // Clock, reset and bus.
  input wire logic clk,
  input wire logic reset_n,
  input wire logic busIn,
  input wire logic busOut,
  input wire logic busOe,
  // Settings and setpoint.
  input wire mbs_cfg_t startCfg,
  input wire mbs_cfg_t activeCfg,
  input wire logic [15:0] mainSetpoint,
  input wire logic [15:0] setpointLowLimit,
  input wire logic [15:0] setpointUpperLimit
);
  // Longest high level while driving: 2 ms at 40 MHz.
  localparam int REL_MAX = 80_000;
  int div, quietCnt, chgCnt, hiCnt;
  logic outQ;
  assign div = CLK_HZ / BAUD_RATE[activeCfg.speed];
  // Quiet time, time since the last bit edge and high time on drive.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      quietCnt <= 0;
      chgCnt <= 0;
      hiCnt <= 0;
    end else begin
      quietCnt <= busIn ? quietCnt + 1 : 0;
      chgCnt <= !busOe ? 0 : (busOut != outQ) ? 1 : chgCnt + 1;
      hiCnt <= (busOe && busOut) ? hiCnt + 1 : 0;
    end
    outQ <= busOut;
  end
  ////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Start and end of a reply on the line.
  sequence s_txBegin;
    $rose(busOe);
  endsequence
  sequence s_txEnd;
    $fell(busOe);
  endsequence
  // Framing and timing of replies.
  a_start_low: assert property (s_txBegin |-> !busOut)
    else $error("reply lacks a start bit");
  a_stop_high: assert property (s_txEnd |-> $past(busOut))
    else $error("driver dropped before a stop bit");
  a_idle_high: assert property (!busOe |-> busOut)
    else $error("line not idle while released");
  a_gap_first: assert property (s_txBegin |-> quietCnt >= GAP_BITS * div)
    else $error("reply began before the silent gap");
  a_bit_time: assert property ($changed(busOut) && chgCnt != 0
    |-> chgCnt % div == 0)
    else $error("bit length differs from line speed");
  a_release_time: assert property (busOe |-> hiCnt <= REL_MAX + 11 * div)
    else $error("driver held too long after a byte");
  // Settings and setpoint.
  a_cfg_load: assert property ($rose(reset_n)
    |-> ##[1:2] activeCfg == startCfg)
    else $error("start settings not applied");
  a_cfg_hold: assert property (busOe && $past(busOe) |-> $stable(activeCfg))
    else $error("line settings changed mid reply");
  a_sp_limits: assert property ($changed(mainSetpoint)
    |-> $signed(mainSetpoint) >= $signed(setpointLowLimit)
    && $signed(mainSetpoint) <= $signed(setpointUpperLimit))
    else $error("setpoint written outside its limits");
endmodule : mbs_modbus_slave_asserts

bind mbs_modbus_slave mbs_modbus_slave_asserts mbs_modbus_slave_asserts_i (
  .clk(clk), .reset_n(reset_n), .busIn(busIn), .busOut(busOut),
  .busOe(busOe), .startCfg(startCfg), .activeCfg(activeCfg),
  .mainSetpoint(mainSetpoint), .setpointLowLimit(setpointLowLimit),
  .setpointUpperLimit(setpointUpperLimit));

// [tb/mbs_host_model.sv]
// Host master model: sends request frames and gathers reply characters.
// Assumes 8 data bits, no parity, one stop bit and a high idle line.
`timescale 1ns/1ps
module mbs_host_model #(
  parameter int DIV = 347
) (
  // Clock and bus level.
  input wire logic clk,
  input wire logic lineIn,
  // Host drive level.
  output logic hostTx
);
  logic listen = 1'b0;
  logic [7:0] rxQ [$];
  logic [7:0] b;
  initial hostTx = 1'b1;
  // One byte step of the frame check.
  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0] d);
    c = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    return c;
  endfunction : crc_step
  // Sends one character, low bit first, at falling edges.
  task automatic send_byte(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      hostTx = f[i];
      repeat (DIV) @(negedge clk);
    end
  endtask : send_byte
  // Only the master opens a transaction; check bytes go low then high.
  task automatic send_frame(input logic [7:0] fr [$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (fr[i]) c = crc_step(c, fr[i]);
    fr.push_back(c[7:0]);
    fr.push_back(c[15:8]);
    foreach (fr[i]) send_byte(fr[i]);
  endtask : send_frame
  // Samples reply characters in the middle of each bit.
  initial forever begin
    @(negedge clk);
    if (listen && !lineIn) begin
      repeat (DIV / 2) @(negedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (DIV) @(negedge clk);
        b[i] = lineIn;
      end
      repeat (DIV) @(negedge clk);
      rxQ.push_back(b);
    end
  end
endmodule : mbs_host_model

// [tb/tb.sv]
// Testbench of the slave port, driven by a host master model.
// Assumes the bus idles high when nobody drives it.
`timescale 1ns/1ps
module tb;
  import mbs_pkg::*;
  localparam int DIV = CLK_HZ / BAUD_RATE[7];
  logic clk, reset_n, busIn, busOut, busOe, hostTx;
  mbs_cfg_t startCfg, activeCfg;
  mbs_proc_t proc;
  logic [15:0] mainSp, spLow, spUp, spHigh, decPos;
  logic [COILS-1:0] coils;
  int n_errors = 0;
  int samples_checked = 0;
  // Wire level: the port while it drives, otherwise the host.
  assign busIn = busOe ? busOut : hostTx;
  mbs_modbus_slave mbs_modbus_slave_i (.clk(clk), .reset_n(reset_n),
    .busIn(busIn), .busOut(busOut), .busOe(busOe), .startCfg(startCfg),
    .proc(proc), .activeCfg(activeCfg), .mainSetpoint(mainSp),
    .setpointLowLimit(spLow), .setpointUpperLimit(spUp),
    .setpointHighLimit(spHigh), .decimalPosition(decPos), .coils(coils));
  mbs_host_model #(.DIV(DIV)) mbs_host_model_i (.clk(clk),
    .lineIn(busIn), .hostTx(hostTx));
  // Clock of 25 ns.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  ////////////////////////////////////////
  // Compares a seen value with the expected one.
  task automatic check(input string what, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Prints the verdict and ends the run.
  task automatic tally_and_finish();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish
  // Broadcast write of 1200 to the setpoint: done, clamped, unanswered.
  task automatic bcast_write();
    logic [7:0] fr [$];
    int talk;
    talk = 0;
    fr = {BCAST_ADDR, FC_WR1, 8'h00, 8'h00, 8'h04, 8'hb0};
    mbs_host_model_i.send_frame(fr);
    repeat (45 * DIV) begin
      @(negedge clk);
      talk += busOe;
    end
    check("broadcast reply", 16'(talk), 16'h0000);
    check("clamped setpoint", mainSp, SP_UPPER_RST);
  endtask : bcast_write
  // Reads setpoint, scaled temperature and clamped power at once.
  task automatic read_three();
    logic [7:0] fr [$];
    logic [7:0] exp [9];
    logic [15:0] c;
    int n;
    fr = {8'h11, FC_READ, 8'h00, 8'h00, 8'h00, 8'h03};
    exp = '{8'h11, FC_READ, 8'h06, 8'h03, 8'he8, 8'h00, 8'h32, 8'h03, 8'he8};
    mbs_host_model_i.send_frame(fr);
    mbs_host_model_i.listen = 1'b1;
    n = 0;
    while (mbs_host_model_i.rxQ.size() < 11 && n < 200 * DIV) begin
      @(negedge clk);
      n++;
    end
    fr = mbs_host_model_i.rxQ;
    check("reply length", 16'(fr.size()), 16'h000b);
    for (int i = 0; i < 9; i++) check("reply byte", {8'h00, fr[i]}, {8'h00, exp[i]});
    c = 16'hffff;
    foreach (fr[i]) c = mbs_host_model_i.crc_step(c, fr[i]);
    check("reply check sum", c, 16'h0000);
  endtask : read_three
  // Main sequence.
  initial begin
    reset_n = 1'b0;
    startCfg = '{speed: 3'h7, parity: PAR_NONE, addr: 8'h11};
    proc = '{pv: 16'h0005, power: 16'h04b0, remoteSp: 16'h0123,
             useRemote: 1'b0, isTemp: 1'b1};
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    bcast_write();
    read_three();
    tally_and_finish();
  end
endmodule : tb
